// ### asm_alert_status.sv
`timescale 1ns/1ps
`include "asm_defs.svh"
// Functional notes
// (R1) Enable loads default mask at reset, update-exit
// (R2) Bit 15 set by group B/C safety
// (R3) Bit 14 set by group A safety
// (R4) Bit 13 set by enabled permanent failure
// (R5) Bit 12 set by masked safety alert
// (R6) Bit 11 set by masked failure alert
// (R7) Bit 10 at boot; bit 9 after scan
// (R8) Bit 7 set per full loop; set here only while enable bit 7 is set
// (R9) Bits 6/5 while charge/discharge switch off
// (R10) Bit 4 while stack voltage low
// (R11) Bit 3 while blow pin driven
// (R12) Bit 2 while balancing active
// (R13) Bit 1 set per single scan; set here only while enable bit 1 is set
// (R14) Bit 0 set on wake from sleep
// (R15) Mask A layout, default 0xFC
// (R16) Mask B layout, default 0xF7
// (R17) Masked alert is nonzero AND test
module asm_alert_status (
  input  wire logic        aclk,                         // System clock, 125 MHz
  input  wire logic        aresetn,                      // Sync reset, active low
  input  wire logic        ce,                           // Clock enable, freezes state
  input  wire logic        s_axi_awvalid,                // Write address valid
  output logic             s_axi_awready,                // Write address ready
  input  wire logic [7:0]  s_axi_awaddr,                 // Write byte address
  input  wire logic        s_axi_wvalid,                 // Write data valid
  output logic             s_axi_wready,                 // Write data ready
  input  wire logic [31:0] s_axi_wdata,                  // Write data
  input  wire logic [3:0]  s_axi_wstrb,                  // Write byte strobes
  output logic             s_axi_bvalid,                 // Write response valid
  input  wire logic        s_axi_bready,                 // Write response ready
  output logic [1:0]       s_axi_bresp,                  // Write response
  input  wire logic        s_axi_arvalid,                // Read address valid
  output logic             s_axi_arready,                // Read address ready
  input  wire logic [7:0]  s_axi_araddr,                 // Read byte address
  output logic             s_axi_rvalid,                 // Read data valid
  input  wire logic        s_axi_rready,                 // Read data ready
  output logic [31:0]      s_axi_rdata,                  // Read data
  output logic [1:0]       s_axi_rresp,                  // Read response
  input  wire logic        safety_group_bc_active,       // Any group B/C safety status
  input  wire logic        safety_group_a_active,        // Any group A safety status
  input  wire logic        permanent_failure,            // Enabled failure triggered
  input  wire logic [7:0]  protection_alert_a,           // Safety alert word A
  input  wire logic [7:0]  protection_alert_b,           // Safety alert word B
  input  wire logic        masked_failure_alert,         // Failure alert hit its mask
  input  wire logic        full_loop_done,               // Full loop done pulse
  input  wire logic        charge_switch_off,            // Charge switch is off
  input  wire logic        discharge_switch_off,         // Discharge switch is off
  input  wire logic        stack_low_voltage,            // Stack below shutdown level
  input  wire logic        blow_pin_driven,              // Blow pin level, async pin
  input  wire logic        balancing_active,             // Cell balancing running
  input  wire logic        single_scan_done,             // Single scan done pulse
  input  wire logic        wake_event,                   // Woken from sleep pulse
  output logic             masked_safety_alert,          // Live masked alert result
  output logic             irq                           // Level interrupt
);

  asm_pkg::asm_state_s st;
  asm_pkg::asm_state_s nx;

  // Byte-lane merge used for the default mask, enable and raw-clear writes
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // Offset decode shared by read and write paths
  function automatic logic mapped(input logic [7:0] a);
    return a == `ASM_OFF_DEF_MASK || a == `ASM_OFF_SF_MASK_A ||
           a == `ASM_OFF_SF_MASK_B || a == `ASM_OFF_ENABLE ||
           a == `ASM_OFF_RAW || a == `ASM_OFF_CTRL;
  endfunction

  logic        sf_hit;
  logic [15:0] set_vec;
  logic        do_wr;
  logic        do_rd;
  logic [15:0] w1c;
  logic [15:0] m16;

  // Masked safety alert: nonzero test of each word ANDed with its mask
  assign sf_hit = |(protection_alert_a & st.sf_mask_a) | // R5 R15 R17
                  |(protection_alert_b & st.sf_mask_b);  // R16 R17

  // Handshakes are combinational; one write and one read in flight.
  // Readies drop while ce is low: a frozen block cannot take a beat
  assign s_axi_awready = ce && !st.aw_ok && !st.bvalid;
  assign s_axi_wready  = ce && !st.w_ok && !st.bvalid;
  assign s_axi_arready = ce && !st.rvalid;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign masked_safety_alert = sf_hit;
  assign irq = |(st.raw & st.enable);

  // Event sources collected into one set vector
  always_comb begin
    set_vec = '0;
    set_vec[`ASM_B_GRP_BC]     = safety_group_bc_active;                       // R2
    set_vec[`ASM_B_GRP_A]      = safety_group_a_active;                        // R3
    set_vec[`ASM_B_PERM_FAIL]  = permanent_failure;                            // R4
    set_vec[`ASM_B_MSK_SF]     = sf_hit;                                       // R5
    set_vec[`ASM_B_MSK_PF]     = masked_failure_alert;                         // R6
    set_vec[`ASM_B_BOOT_START] = st.boot == asm_pkg::ASM_BOOT;                 // R7
    set_vec[`ASM_B_BOOT_DONE]  = st.boot == asm_pkg::ASM_INIT && single_scan_done; // R7
    set_vec[`ASM_B_FULL_LOOP]  = full_loop_done && st.enable[`ASM_B_FULL_LOOP]; // R8
    set_vec[`ASM_B_CHG_OFF]    = charge_switch_off;                            // R9
    set_vec[`ASM_B_DSG_OFF]    = discharge_switch_off;                         // R9
    set_vec[`ASM_B_STACK_LOW]  = stack_low_voltage;                            // R10
    set_vec[`ASM_B_BLOW_PIN]   = st.blow_s2;                                   // R11
    set_vec[`ASM_B_BALANCE]    = balancing_active;                             // R12
    set_vec[`ASM_B_SCAN_DONE]  = single_scan_done && st.enable[`ASM_B_SCAN_DONE]; // R13
    set_vec[`ASM_B_WAKE]       = wake_event;                                   // R14
  end

  // Next-state logic for the whole block
  always_comb begin
    nx    = st;
    do_wr = st.aw_ok && st.w_ok && !st.bvalid;
    do_rd = s_axi_arvalid && !st.rvalid;
    w1c   = '0;
    m16   = merge16(16'h0000, st.wdata, st.wstrb);

    // Pin synchroniser; only the second stage is read
    nx.blow_s1 = blow_pin_driven;
    nx.blow_s2 = st.blow_s1;

    // Capture address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nx.aw_ok   = 1'b1;
      nx.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nx.w_ok  = 1'b1;
      nx.wdata = s_axi_wdata;
      nx.wstrb = s_axi_wstrb;
    end

    // Register write once both halves are held
    if (do_wr) begin
      nx.aw_ok  = 1'b0;
      nx.w_ok   = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp  = mapped(st.aw_addr) ? `ASM_RESP_OKAY : `ASM_RESP_SLVERR;
      case (st.aw_addr)
        `ASM_OFF_DEF_MASK: begin
          nx.def_mask = merge16(st.def_mask, st.wdata, st.wstrb);
        end
        `ASM_OFF_SF_MASK_A: begin
          if (st.wstrb[0]) begin
            nx.sf_mask_a = st.wdata[7:0]; // R15
          end
        end
        `ASM_OFF_SF_MASK_B: begin
          if (st.wstrb[0]) begin
            nx.sf_mask_b = st.wdata[7:0]; // R16
          end
        end
        `ASM_OFF_ENABLE: begin
          nx.enable = merge16(st.enable, st.wdata, st.wstrb);
        end
        `ASM_OFF_RAW: begin
          w1c = m16;
        end
        `ASM_OFF_CTRL: begin
          if (st.wstrb[0]) begin
            nx.cfg_upd = st.wdata[`ASM_B_CFG_UPD];
          end
        end
        default: begin
        end
      endcase
    end
    if (st.bvalid && s_axi_bready) begin
      nx.bvalid = 1'b0;
    end

    // Leaving settings-update mode reloads the enable word
    if (st.cfg_upd && !nx.cfg_upd) begin
      nx.enable = st.def_mask; // R1
    end

    // Sticky raw status, set wins over a same-cycle clear
    nx.raw = (st.raw & ~w1c) | set_vec;
    nx.raw[`ASM_B_RSVD] = 1'b0;

    // Boot sequencing: started at once, done after first scan
    case (st.boot)
      asm_pkg::ASM_BOOT: begin
        nx.boot = asm_pkg::ASM_INIT; // R7
      end
      asm_pkg::ASM_INIT: begin
        if (single_scan_done) begin
          nx.boot = asm_pkg::ASM_RUN; // R7
        end
      end
      asm_pkg::ASM_RUN: begin
        nx.boot = asm_pkg::ASM_RUN;
      end
      default: begin
        nx.boot = asm_pkg::ASM_BOOT;
      end
    endcase

    // Read path answers one cycle after the address is taken
    if (do_rd) begin
      nx.rvalid = 1'b1;
      nx.rdata  = '0;
      nx.rresp  = mapped(s_axi_araddr) ? `ASM_RESP_OKAY : `ASM_RESP_SLVERR;
      case (s_axi_araddr)
        `ASM_OFF_DEF_MASK: begin
          nx.rdata[15:0] = st.def_mask;
        end
        `ASM_OFF_SF_MASK_A: begin
          nx.rdata[7:0] = st.sf_mask_a;
        end
        `ASM_OFF_SF_MASK_B: begin
          nx.rdata[7:0] = st.sf_mask_b;
        end
        `ASM_OFF_ENABLE: begin
          nx.rdata[15:0] = st.enable;
        end
        `ASM_OFF_RAW: begin
          nx.rdata[15:0] = st.raw;
        end
        `ASM_OFF_CTRL: begin
          nx.rdata[`ASM_B_CFG_UPD] = st.cfg_upd;
        end
        default: begin
          nx.rdata = '0;
        end
      endcase
    end else if (st.rvalid && s_axi_rready) begin
      nx.rvalid = 1'b0;
    end
  end

  // State register; reset loads the default mask into the enable word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st           <= '0;
      st.def_mask  <= `ASM_RST_DEF_MASK;
      st.sf_mask_a <= `ASM_RST_SF_MASK_A; // R15
      st.sf_mask_b <= `ASM_RST_SF_MASK_B; // R16
      st.enable    <= `ASM_RST_DEF_MASK;  // R1
      st.boot      <= asm_pkg::ASM_BOOT;
    end else if (ce) begin
      st <= nx;
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  enable_reload_a: assert property (ce && st.cfg_upd && !nx.cfg_upd |=> // R1
      st.enable == $past(st.def_mask)) else $error("enable not reloaded");
  reset_masks_a: assert property ($rose(aresetn) |-> st.enable == `ASM_RST_DEF_MASK && // R15
      st.sf_mask_a == `ASM_RST_SF_MASK_A && st.sf_mask_b == `ASM_RST_SF_MASK_B)
      else $error("reset values wrong");
  group_bc_a: assert property (ce && safety_group_bc_active |=> st.raw[`ASM_B_GRP_BC]) // R2
      else $error("bit 15 missed");
  group_a_a: assert property (ce && safety_group_a_active |=> st.raw[`ASM_B_GRP_A]) // R3
      else $error("bit 14 missed");
  perm_fail_a: assert property (ce && permanent_failure |=> st.raw[`ASM_B_PERM_FAIL]) // R4
      else $error("bit 13 missed");
  masked_sf_a: assert property (ce && (|(protection_alert_a & st.sf_mask_a) || // R5
      |(protection_alert_b & st.sf_mask_b)) |=> st.raw[`ASM_B_MSK_SF])
      else $error("bit 12 missed");
  masked_pf_a: assert property (ce && masked_failure_alert |=> st.raw[`ASM_B_MSK_PF]) // R6
      else $error("bit 11 missed");
  boot_start_a: assert property ($rose(aresetn) ##1 ce |=> st.raw[`ASM_B_BOOT_START]) // R7
      else $error("bit 10 missed");
  full_loop_a: assert property (ce && full_loop_done && st.enable[`ASM_B_FULL_LOOP] |=> // R8
      st.raw[`ASM_B_FULL_LOOP]) else $error("bit 7 missed");
  switch_off_a: assert property (ce && charge_switch_off |=> st.raw[`ASM_B_CHG_OFF]) // R9
      else $error("bit 6 missed");
  dsg_off_a: assert property (ce && discharge_switch_off |=> st.raw[`ASM_B_DSG_OFF]) // R9
      else $error("bit 5 missed");
  boot_done_a: assert property (ce && st.boot == asm_pkg::ASM_INIT && single_scan_done |=> // R7
      st.raw[`ASM_B_BOOT_DONE] && st.boot == asm_pkg::ASM_RUN) else $error("bit 9 missed");
  stack_low_a: assert property (ce && stack_low_voltage |=> st.raw[`ASM_B_STACK_LOW]) // R10
      else $error("bit 4 missed");
  blow_pin_a: assert property (ce && st.blow_s2 |=> st.raw[`ASM_B_BLOW_PIN]) // R11
      else $error("bit 3 missed");
  balance_a: assert property (ce && balancing_active |=> st.raw[`ASM_B_BALANCE]) // R12
      else $error("bit 2 missed");
  scan_done_a: assert property (ce && single_scan_done && st.enable[`ASM_B_SCAN_DONE] |=> // R13
      st.raw[`ASM_B_SCAN_DONE]) else $error("bit 1 missed");
  wake_bit_a: assert property (ce && wake_event |=> st.raw[`ASM_B_WAKE]) // R14
      else $error("bit 0 missed");
  zero_mask_a: assert property (!(|(protection_alert_a & st.sf_mask_a)) && // R17
      !(|(protection_alert_b & st.sf_mask_b)) |-> !masked_safety_alert)
      else $error("alert set with zero products");

  // Sticky bits: a write of ones clears when the source is quiet
  raw_clear_a: assert property (ce && do_wr && st.aw_addr == `ASM_OFF_RAW && // R14
      st.wstrb[0] && st.wdata[`ASM_B_WAKE] && !wake_event |=> !st.raw[`ASM_B_WAKE])
      else $error("wake bit not cleared");
  irq_raise_a: assert property (ce && wake_event && st.enable[`ASM_B_WAKE] |=> irq) // R14
      else $error("unmasked wake gave no interrupt");

  // Bus answers: one response per request, in the promised cycle
  write_answer_a: assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready ##1 ce |=> s_axi_bvalid) else $error("write not answered");
  read_answer_a: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
  bresp_once_a: assert property (ce && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answered twice");
  rresp_once_a: assert property (ce && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answered twice");
  unmapped_wr_a: assert property (ce && do_wr && !mapped(st.aw_addr) |=>
      s_axi_bresp == `ASM_RESP_SLVERR) else $error("unmapped write not refused");

  // Clock enable low: nothing taken, nothing moves
  ready_gate_a: assert property (!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
      else $error("ready high while frozen");
  state_freeze_a: assert property (!ce |=> $stable(st.raw) && $stable(st.enable))
      else $error("state moved while frozen");

endmodule

// ### asm_defs.svh
`ifndef ASM_DEFS_SVH
`define ASM_DEFS_SVH

// Register byte offsets
`define ASM_OFF_DEF_MASK   8'h00
`define ASM_OFF_SF_MASK_A  8'h04
`define ASM_OFF_SF_MASK_B  8'h08
`define ASM_OFF_ENABLE     8'h0C
`define ASM_OFF_RAW        8'h10
`define ASM_OFF_CTRL       8'h14

// Widths
`define ASM_ADDR_W         8
`define ASM_ALERT_W        16
`define ASM_SF_W           8

// Reset values
`define ASM_RST_DEF_MASK   16'hF800
`define ASM_RST_SF_MASK_A  8'hFC
`define ASM_RST_SF_MASK_B  8'hF7

// Raw alert bit positions
`define ASM_B_GRP_BC       15
`define ASM_B_GRP_A        14
`define ASM_B_PERM_FAIL    13
`define ASM_B_MSK_SF       12
`define ASM_B_MSK_PF       11
`define ASM_B_BOOT_START   10
`define ASM_B_BOOT_DONE    9
`define ASM_B_RSVD         8
`define ASM_B_FULL_LOOP    7
`define ASM_B_CHG_OFF      6
`define ASM_B_DSG_OFF      5
`define ASM_B_STACK_LOW    4
`define ASM_B_BLOW_PIN     3
`define ASM_B_BALANCE      2
`define ASM_B_SCAN_DONE    1
`define ASM_B_WAKE         0

// Control register bit: settings-update mode
`define ASM_B_CFG_UPD      0

// AXI responses
`define ASM_RESP_OKAY      2'h0
`define ASM_RESP_SLVERR    2'h2

`endif

// ### asm_pkg.sv
`include "asm_defs.svh"

package asm_pkg;

  // Power-up sequencing of the status word
  typedef enum logic [1:0] {
    ASM_BOOT,
    ASM_INIT,
    ASM_RUN
  } asm_boot_e;

  // Complete state of the block
  typedef struct packed {
    logic [`ASM_ALERT_W-1:0] def_mask;
    logic [`ASM_SF_W-1:0]    sf_mask_a;
    logic [`ASM_SF_W-1:0]    sf_mask_b;
    logic [`ASM_ALERT_W-1:0] enable;
    logic [`ASM_ALERT_W-1:0] raw;
    logic                    cfg_upd;
    asm_boot_e               boot;
    logic                    aw_ok;
    logic [`ASM_ADDR_W-1:0]  aw_addr;
    logic                    w_ok;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
    logic                    blow_s1;
    logic                    blow_s2;
  } asm_state_s;

endpackage

// ### test_alarm_status_mask_logic.sv
`timescale 1ns/1ps
`include "asm_defs.svh"
module test_alarm_status_mask_logic;
  // One row: level sources, alert words, expected raw word
  typedef struct packed {
    logic [11:0] lv;
    logic [7:0]  aa;
    logic [7:0]  ab;
    logic [15:0] exp;
  } asm_row_s;
  logic        aclk, aresetn, ce_r, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, msa, irq;
  logic [7:0]  awaddr, araddr, aa_r, ab_r;
  logic [31:0] wdata, rdata, rd_d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic [11:0] lv_r;
  int          num_errors, checked, cycles;
  asm_row_s    rows [17];

  asm_alert_status dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce_r),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .safety_group_bc_active(lv_r[11]), .safety_group_a_active(lv_r[10]),
    .permanent_failure(lv_r[9]), .masked_failure_alert(lv_r[8]),
    .full_loop_done(lv_r[7]), .charge_switch_off(lv_r[6]),
    .discharge_switch_off(lv_r[5]), .stack_low_voltage(lv_r[4]),
    .blow_pin_driven(lv_r[3]), .balancing_active(lv_r[2]),
    .single_scan_done(lv_r[1]), .wake_event(lv_r[0]),
    .protection_alert_a(aa_r), .protection_alert_b(ab_r),
    .masked_safety_alert(msa), .irq(irq)
  );

  // Free-running 125 MHz clock
  initial aclk = 1'b0;
  always #4 aclk = ~aclk;

  task automatic give_verdict();
    $display("counts: checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      num_errors++;
      $display("[ERR] t=%0t timeout got=%h exp=%h", $time, cycles, 8000);
      give_verdict();
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write: both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd(a, rd_d, rsp);
    chk_word(rd_d, exp);
  endtask

  // Apply sources for a few edges; blow pin needs three to land
  task automatic drive(input logic [11:0] lv, input logic [7:0] aa, input logic [7:0] ab);
    lv_r <= lv;
    aa_r <= aa;
    ab_r <= ab;
    repeat (4) @(posedge aclk);
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, lv_r, aa_r, ab_r} = '0;
    {num_errors, checked, cycles} = '0;
    wstrb = 4'hF;
    ce_r = 1'b1;
    aresetn = 1'b0;
    rows = '{'{12'h002, 8'h00, 8'h00, 16'h0202}, '{12'h800, 8'h00, 8'h00, 16'h8000},
             '{12'h400, 8'h00, 8'h00, 16'h4000}, '{12'h200, 8'h00, 8'h00, 16'h2000},
             '{12'h100, 8'h00, 8'h00, 16'h0800}, '{12'h080, 8'h00, 8'h00, 16'h0080},
             '{12'h040, 8'h00, 8'h00, 16'h0040}, '{12'h020, 8'h00, 8'h00, 16'h0020},
             '{12'h010, 8'h00, 8'h00, 16'h0010}, '{12'h008, 8'h00, 8'h00, 16'h0008},
             '{12'h004, 8'h00, 8'h00, 16'h0004}, '{12'h002, 8'h00, 8'h00, 16'h0002},
             '{12'h001, 8'h00, 8'h00, 16'h0001}, '{12'h000, 8'h80, 8'h00, 16'h1000},
             '{12'h000, 8'h03, 8'h00, 16'h0000}, '{12'h000, 8'h00, 8'h08, 16'h0000},
             '{12'h000, 8'h00, 8'h01, 16'h1000}};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd_chk(`ASM_OFF_RAW, 32'h00000400);
    rd_chk(`ASM_OFF_DEF_MASK, 32'h0000F800);
    rd_chk(`ASM_OFF_ENABLE, 32'h0000F800);
    rd_chk(`ASM_OFF_SF_MASK_A, 32'h000000FC);
    rd_chk(`ASM_OFF_SF_MASK_B, 32'h000000F7);
    $display("test reset_values done");
    // All sources enabled so the scan bits and irq can show
    wr(`ASM_OFF_ENABLE, 32'h0000FFFF, rsp);
    chk_word({30'h0, rsp}, {30'h0, `ASM_RESP_OKAY});
    foreach (rows[i]) begin
      wr(`ASM_OFF_RAW, 32'h0000FFFF, rsp);
      drive(rows[i].lv, rows[i].aa, rows[i].ab);
      chk_bit(msa, rows[i].exp[12]);
      chk_bit(irq, |rows[i].exp);
      drive(12'h000, 8'h00, 8'h00);
      rd_chk(`ASM_OFF_RAW, {16'h0000, rows[i].exp});
    end
    $display("test source_rows done");
    // Enable reload only on leaving settings-update mode
    wr(`ASM_OFF_DEF_MASK, 32'h000000AA, rsp);
    rd_chk(`ASM_OFF_ENABLE, 32'h0000FFFF);
    wr(`ASM_OFF_CTRL, 32'h00000001, rsp);
    wr(`ASM_OFF_CTRL, 32'h00000000, rsp);
    rd_chk(`ASM_OFF_ENABLE, 32'h000000AA);
    $display("test mask_reload done");
    // Wake is masked by the reloaded enable, then unmasked and cleared
    wr(`ASM_OFF_RAW, 32'h0000FFFF, rsp);
    drive(12'h001, 8'h00, 8'h00);
    drive(12'h000, 8'h00, 8'h00);
    chk_bit(irq, 1'b0);
    rd_chk(`ASM_OFF_RAW, 32'h00000001);
    wr(`ASM_OFF_ENABLE, 32'h00000001, rsp);
    chk_bit(irq, 1'b1);
    wr(`ASM_OFF_RAW, 32'h00000001, rsp);
    chk_bit(irq, 1'b0);
    rd_chk(`ASM_OFF_RAW, 32'h00000000);
    $display("test interrupt done");
    // Frozen block ignores a wake and refuses bus beats
    ce_r <= 1'b0;
    drive(12'h001, 8'h00, 8'h00);
    chk_bit(awready, 1'b0);
    ce_r <= 1'b1;
    drive(12'h000, 8'h00, 8'h00);
    rd_chk(`ASM_OFF_RAW, 32'h00000000);
    $display("test clock_enable done");
    // Changed alert masks steer the combined bit
    wr(`ASM_OFF_SF_MASK_A, 32'h0000007F, rsp);
    drive(12'h000, 8'h80, 8'h00);
    chk_bit(msa, 1'b0);
    drive(12'h000, 8'h40, 8'h00);
    chk_bit(msa, 1'b1);
    wr(`ASM_OFF_SF_MASK_B, 32'h00000008, rsp);
    drive(12'h000, 8'h00, 8'h08);
    chk_bit(msa, 1'b1);
    drive(12'h000, 8'h00, 8'h00);
    $display("test mask_change done");
    // Unmapped place answers with an error and reads zero
    wr(8'h20, 32'h00000001, rsp);
    chk_word({30'h0, rsp}, {30'h0, `ASM_RESP_SLVERR});
    rd(8'h20, rd_d, rsp);
    chk_word(rd_d, 32'h00000000);
    chk_word({30'h0, rsp}, {30'h0, `ASM_RESP_SLVERR});
    $display("test unmapped done");
    // Second reset in mid-run restores the default enable
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(`ASM_OFF_ENABLE, 32'h0000F800);
    rd_chk(`ASM_OFF_SF_MASK_A, 32'h000000FC);
    $display("test second_reset done");
    give_verdict();
  end
endmodule
